/* File: common/msi_pkg.sv */
// msi_pkg: constants, register map and sequencer states of the station id controller.
// assumes a 10 MHz system clock; slower rates are counted from it.
package msi_pkg;

    // clock and time bases
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_HZ        = 10_000_000;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S      = 1000;
    localparam int MS_PER_DS     = 100;
    localparam int S_PER_MIN     = 60;
    localparam int TONE_WRAP     = CLK_HZ / 2;

    // morse element timing: dot in ms at 1 wpm, the rest in dot lengths
    localparam int DOT_MS     = 1200;
    localparam int DASH_DOTS  = 3;
    localparam int ELEM_GAP   = 1;
    localparam int CHAR_GAP   = 3;
    localparam int WORD_GAP   = 7;

    // register bus
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    localparam logic [8:0] OFS_CTRL     = 9'h000;
    localparam logic [8:0] OFS_TONE     = 9'h001;
    localparam logic [8:0] OFS_REPEAT   = 9'h002;
    localparam logic [8:0] OFS_WPM      = 9'h003;
    localparam logic [8:0] OFS_WAIT     = 9'h004;
    localparam logic [8:0] OFS_PORCH    = 9'h005;
    localparam logic [8:0] OFS_TIMEOUT  = 9'h006;
    localparam logic [8:0] OFS_DROPOUT  = 9'h007;
    localparam logic [8:0] OFS_ID1_LEN  = 9'h008;
    localparam logic [8:0] OFS_ID2_LEN  = 9'h009;
    localparam logic [8:0] OFS_STATUS   = 9'h00A;
    localparam logic [8:0] OFS_ELAPSED  = 9'h00B;
    localparam logic [8:0] OFS_ID1_BASE = 9'h040;
    localparam logic [8:0] OFS_ID2_BASE = 9'h100;

    // control register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_SEL_BIT  = 2;

    // reset values
    localparam logic [2:0]  RST_CTRL    = 3'h0;
    localparam logic [11:0] RST_TONE    = 12'h3E8;
    localparam logic [6:0]  RST_REPEAT  = 7'h0A;
    localparam logic [6:0]  RST_WPM     = 7'h14;
    localparam logic [6:0]  RST_WAIT    = 7'h05;
    localparam logic [6:0]  RST_PORCH   = 7'h05;
    localparam logic [9:0]  RST_TIMEOUT = 10'h000;
    localparam logic [6:0]  RST_DROPOUT = 7'h03;

    // legal ranges, writes are clamped into them
    localparam int TONE_MIN = 1;
    localparam int TONE_MAX = 3000;
    localparam int MIN1     = 1;
    localparam int MAX99    = 99;
    localparam int MIN0     = 0;
    localparam int TOUT_MAX = 999;
    localparam int ID1_MAX  = 16;
    localparam int ID2_MAX  = 130;

    typedef enum logic [2:0] {
        MSI_IDLE  = 3'b000,
        MSI_PORCH = 3'b001,
        MSI_LOAD  = 3'b010,
        MSI_ELEM  = 3'b011,
        MSI_MARK  = 3'b100,
        MSI_GAP   = 3'b101
    } msi_seq_t;

endpackage

/* File: hw/msi_morse_station_id_controller.sv */
// msi_morse_station_id_controller: repeater keying and morse station identifier.
// assumes a register port on clock_in and asynchronous active-high pins.
// How it works
// - first identifier holds up to 16 characters
// - second string holds up to 130 characters
// - tone settable 1 to 3000 Hz, 1 Hz
// - repeat interval 1 to 99 minutes
// - after-activity mode sends after activity, interval elapsed
// - continuous mode sends every interval regardless
// - speed settable 1 to 99 words_per_minute
// - wait 1 to 99 s after carrier loss
// - key transmitter front porch before tone
// - timeout zero off, else drop after seconds
// - hold key dropout seconds after carrier loss
// - key while keying request is active
// - hold key dropout period after request ends
`timescale 1ns/1ps
module msi_morse_station_id_controller #(
    parameter int MS_CYCLES = msi_pkg::MS_CYCLES,
    parameter int ID1_DEPTH = msi_pkg::ID1_MAX,
    parameter int ID2_DEPTH = msi_pkg::ID2_MAX
) (
    // clock and reset
    input  wire logic                        clock_in,
    input  wire logic                        reset_in,
    // register port
    input  wire logic [msi_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [msi_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [msi_pkg::DATA_W-1:0]  rdata_out,
    // station pins
    input  wire logic                        carrier_squelch_detect_in,
    input  wire logic                        inhibit_in,
    input  wire logic                        keying_request_in,
    output logic                             transmitter_key_out,
    output logic                             tone_out,
    output logic                             id_active_out
);
    import msi_pkg::*;

    localparam int MSW = $clog2(MS_CYCLES + 1);
    localparam int I1W = $clog2(ID1_DEPTH);

    typedef struct packed {
        logic [2:0]                  ctrl;
        logic [11:0]                 tone_hz;
        logic [6:0]                  repeat_min;
        logic [6:0]                  words_per_minute;
        logic [6:0]                  wait_s;
        logic [6:0]                  porch_ds;
        logic [9:0]                  timeout_s;
        logic [6:0]                  dropout_s;
        logic [4:0]                  id1_len;
        logic [7:0]                  id2_len;
        logic [ID1_DEPTH-1:0][7:0]   id1;
        logic [ID2_DEPTH-1:0][7:0]   id2;
        logic [2:0]                  csd_s;
        logic [2:0]                  inh_s;
        logic [2:0]                  req_s;
        logic                        csd;
        logic                        inh;
        logic                        req;
        logic [MSW-1:0]              ms_cnt;
        logic [9:0]                  ms_in_s;
        logic [12:0]                 elapsed_s;
        logic                        act_seen;
        logic [16:0]                 quiet_ms;
        logic [16:0]                 hang_ms;
        logic [19:0]                 key_ms;
        logic                        timed_out;
        msi_seq_t                    seq;
        logic [13:0]                 porch_ms;
        logic [7:0]                  idx;
        logic [7:0]                  pat;
        logic [2:0]                  cnt;
        logic                        to_load;
        logic [10:0]                 dot_acc;
        logic [22:0]                 tone_acc;
        logic                        tone_lvl;
        logic                        key_q;
        logic                        tone_q;
        logic [15:0]                 rdata;
    } msi_state_t;

    msi_state_t s_q;
    msi_state_t s_d;

    logic        ms_tick;
    logic        sec_tick;
    logic        dot_tick;
    logic        activity;
    logic        repeat_due;
    logic        want_key;
    logic        start_id;
    logic [7:0]  cur_len;
    logic [7:0]  cur_chr;
    logic [11:0] dot_sum;
    logic [23:0] tone_sum;

    function automatic logic [15:0] msi_clamp(input logic [15:0] v, input int lo, input int hi);
        if (int'(v) < lo) begin
            return 16'(lo);
        end
        if (int'(v) > hi) begin
            return 16'(hi);
        end
        return v;
    endfunction

    always_comb begin
        s_d        = s_q;
        ms_tick    = 1'b0;
        sec_tick   = 1'b0;
        dot_tick   = 1'b0;
        start_id   = 1'b0;
        cur_len    = 8'h00;
        cur_chr    = 8'h00;
        dot_sum    = 12'h000;
        tone_sum   = 24'h000000;

        // register writes
        if (wr_in) begin
            unique case (addr_in)
                OFS_CTRL:    s_d.ctrl = wdata_in[2:0];
                OFS_TONE:    s_d.tone_hz = 12'(msi_clamp(wdata_in, TONE_MIN, TONE_MAX));
                OFS_REPEAT:  s_d.repeat_min = 7'(msi_clamp(wdata_in, MIN1, MAX99));
                OFS_WPM:     s_d.words_per_minute = 7'(msi_clamp(wdata_in, MIN1, MAX99));
                OFS_WAIT:    s_d.wait_s = 7'(msi_clamp(wdata_in, MIN1, MAX99));
                OFS_PORCH:   s_d.porch_ds = 7'(msi_clamp(wdata_in, MIN0, MAX99));
                OFS_TIMEOUT: s_d.timeout_s = 10'(msi_clamp(wdata_in, MIN0, TOUT_MAX));
                OFS_DROPOUT: s_d.dropout_s = 7'(msi_clamp(wdata_in, MIN0, MAX99));
                OFS_ID1_LEN: s_d.id1_len = 5'(msi_clamp(wdata_in, MIN0, ID1_DEPTH));
                OFS_ID2_LEN: s_d.id2_len = 8'(msi_clamp(wdata_in, MIN0, ID2_DEPTH));
                default: begin
                    if (addr_in >= OFS_ID1_BASE && int'(addr_in) < int'(OFS_ID1_BASE) + ID1_DEPTH) begin
                        s_d.id1[I1W'(addr_in - OFS_ID1_BASE)] = wdata_in[7:0];
                    end
                    if (addr_in >= OFS_ID2_BASE && int'(addr_in) < int'(OFS_ID2_BASE) + ID2_DEPTH) begin
                        s_d.id2[8'(addr_in - OFS_ID2_BASE)] = wdata_in[7:0];
                    end
                end
            endcase
        end

        // three-stage pin synchronisers, taken when stages two and three agree
        s_d.csd_s = {s_q.csd_s[1:0], carrier_squelch_detect_in};
        s_d.inh_s = {s_q.inh_s[1:0], inhibit_in};
        s_d.req_s = {s_q.req_s[1:0], keying_request_in};
        if (s_q.csd_s[2] == s_q.csd_s[1]) begin
            s_d.csd = s_q.csd_s[2];
        end
        if (s_q.inh_s[2] == s_q.inh_s[1]) begin
            s_d.inh = s_q.inh_s[2];
        end
        if (s_q.req_s[2] == s_q.req_s[1]) begin
            s_d.req = s_q.req_s[2];
        end

        // millisecond and second enables
        if (int'(s_q.ms_cnt) == MS_CYCLES - 1) begin
            s_d.ms_cnt = '0;
            ms_tick    = 1'b1;
        end else begin
            s_d.ms_cnt = s_q.ms_cnt + 1'b1;
        end
        if (ms_tick) begin
            if (int'(s_q.ms_in_s) == MS_PER_S - 1) begin
                s_d.ms_in_s = 10'h000;
                sec_tick    = 1'b1;
            end else begin
                s_d.ms_in_s = s_q.ms_in_s + 1'b1;
            end
        end

        activity = s_q.csd | s_q.inh | s_q.req;

        if (sec_tick && s_q.elapsed_s != 13'h1FFF) begin
            s_d.elapsed_s = s_q.elapsed_s + 1'b1;
        end
        repeat_due = int'(s_q.elapsed_s) >= int'(s_q.repeat_min) * S_PER_MIN;

        if (activity) begin
            s_d.quiet_ms = 17'h00000;
        end else if (ms_tick && s_q.quiet_ms != 17'h1FFFF) begin
            s_d.quiet_ms = s_q.quiet_ms + 1'b1;
        end

        if (s_q.csd | s_q.req) begin
            s_d.hang_ms = 17'(int'(s_q.dropout_s) * MS_PER_S);
        end else if (ms_tick && s_q.hang_ms != 17'h00000) begin
            s_d.hang_ms = s_q.hang_ms - 1'b1;
        end

        want_key = s_q.req | s_q.csd | (s_q.hang_ms != 17'h00000) | (s_q.seq != MSI_IDLE);

        if (!want_key) begin
            s_d.key_ms = 20'h00000;
        end else if (ms_tick && !s_q.timed_out) begin
            s_d.key_ms = s_q.key_ms + 1'b1;
        end
        if (s_q.timed_out) begin
            s_d.hang_ms = 17'h00000;
            if (!s_q.csd && !s_q.req) begin
                s_d.timed_out = 1'b0;
            end
        end else if (s_q.timeout_s != 10'h000 && want_key &&
                     int'(s_q.key_ms) >= int'(s_q.timeout_s) * MS_PER_S) begin
            s_d.timed_out = 1'b1;
        end

        if (activity) begin
            s_d.act_seen = 1'b1;
        end

        cur_len = s_q.ctrl[CTRL_SEL_BIT] ? s_q.id2_len : 8'(s_q.id1_len);
        if (s_q.ctrl[CTRL_SEL_BIT]) begin
            cur_chr = s_q.id2[s_q.idx];
        end else begin
            cur_chr = s_q.id1[I1W'(s_q.idx)];
        end

        if (s_q.ctrl[CTRL_EN_BIT] && s_q.seq == MSI_IDLE && !s_q.timed_out &&
            cur_len != 8'h00 && repeat_due) begin
            if (s_q.ctrl[CTRL_MODE_BIT]) begin
                start_id = s_q.act_seen && !activity &&
                           int'(s_q.quiet_ms) >= int'(s_q.wait_s) * MS_PER_S;
            end else begin
                start_id = 1'b1;
            end
        end

        // dot enable, 1200 ms divided by speed
        if (ms_tick && s_q.seq != MSI_IDLE && s_q.seq != MSI_PORCH) begin
            dot_sum = 12'(s_q.dot_acc) + 12'(s_q.words_per_minute);
            if (int'(dot_sum) >= DOT_MS) begin
                dot_tick  = 1'b1;
                s_d.dot_acc = 11'(int'(dot_sum) - DOT_MS);
            end else begin
                s_d.dot_acc = 11'(dot_sum);
            end
        end

        unique case (s_q.seq)
            MSI_IDLE: begin
                if (start_id) begin
                    s_d.seq       = MSI_PORCH;
                    s_d.porch_ms  = 14'h0000;
                    s_d.elapsed_s = 13'h0000;
                    s_d.act_seen  = activity;
                end
            end
            MSI_PORCH: begin
                if (ms_tick) begin
                    s_d.porch_ms = s_q.porch_ms + 1'b1;
                end
                if (int'(s_q.porch_ms) >= int'(s_q.porch_ds) * MS_PER_DS) begin
                    s_d.seq     = MSI_LOAD;
                    s_d.idx     = 8'h00;
                    s_d.dot_acc = 11'h000;
                end
            end
            MSI_LOAD: begin
                if (s_q.idx >= cur_len) begin
                    s_d.seq = MSI_IDLE;
                end else begin
                    s_d.idx = s_q.idx + 1'b1;
                    if (cur_chr <= 8'h01) begin
                        // word space tops up the character gap already sent
                        s_d.cnt     = 3'(WORD_GAP - CHAR_GAP);
                        s_d.to_load = 1'b1;
                        s_d.seq     = MSI_GAP;
                    end else begin
                        s_d.pat = cur_chr;
                        s_d.seq = MSI_ELEM;
                    end
                end
            end
            MSI_ELEM: begin
                s_d.cnt = s_q.pat[0] ? 3'(DASH_DOTS) : 3'h1;
                s_d.pat = s_q.pat >> 1;
                s_d.seq = MSI_MARK;
            end
            MSI_MARK: begin
                if (dot_tick) begin
                    if (s_q.cnt == 3'h1) begin
                        s_d.to_load = (s_q.pat == 8'h01);
                        s_d.cnt     = (s_q.pat == 8'h01) ? 3'(CHAR_GAP) : 3'(ELEM_GAP);
                        s_d.seq     = MSI_GAP;
                    end else begin
                        s_d.cnt = s_q.cnt - 1'b1;
                    end
                end
            end
            MSI_GAP: begin
                if (dot_tick) begin
                    if (s_q.cnt == 3'h1) begin
                        s_d.seq = s_q.to_load ? MSI_LOAD : MSI_ELEM;
                    end else begin
                        s_d.cnt = s_q.cnt - 1'b1;
                    end
                end
            end
            default: s_d.seq = MSI_IDLE;
        endcase

        // abort an identifier on time-out or disable
        if (s_q.timed_out || !s_q.ctrl[CTRL_EN_BIT]) begin
            s_d.seq = MSI_IDLE;
        end

        // tone by phase accumulation, 1 Hz steps
        if (s_q.seq == MSI_MARK) begin
            tone_sum = 24'(s_q.tone_acc) + 24'(s_q.tone_hz);
            if (int'(tone_sum) >= TONE_WRAP) begin
                s_d.tone_acc = 23'(int'(tone_sum) - TONE_WRAP);
                s_d.tone_lvl = ~s_q.tone_lvl;
            end else begin
                s_d.tone_acc = 23'(tone_sum);
            end
        end else begin
            s_d.tone_acc = 23'h000000;
            s_d.tone_lvl = 1'b0;
        end

        s_d.tone_q = (s_d.seq == MSI_MARK) & s_d.tone_lvl;
        s_d.key_q  = want_key & ~s_q.timed_out;

        // register reads, data valid in the following cycle only
        s_d.rdata = 16'h0000;
        if (rd_in) begin
            unique case (addr_in)
                OFS_CTRL:    s_d.rdata = 16'(s_q.ctrl);
                OFS_TONE:    s_d.rdata = 16'(s_q.tone_hz);
                OFS_REPEAT:  s_d.rdata = 16'(s_q.repeat_min);
                OFS_WPM:     s_d.rdata = 16'(s_q.words_per_minute);
                OFS_WAIT:    s_d.rdata = 16'(s_q.wait_s);
                OFS_PORCH:   s_d.rdata = 16'(s_q.porch_ds);
                OFS_TIMEOUT: s_d.rdata = 16'(s_q.timeout_s);
                OFS_DROPOUT: s_d.rdata = 16'(s_q.dropout_s);
                OFS_ID1_LEN: s_d.rdata = 16'(s_q.id1_len);
                OFS_ID2_LEN: s_d.rdata = 16'(s_q.id2_len);
                OFS_STATUS:  s_d.rdata = {5'h00, s_q.seq, s_q.timed_out, s_q.key_q,
                                          s_q.tone_q, s_q.act_seen, repeat_due,
                                          s_q.req, s_q.inh, s_q.csd};
                OFS_ELAPSED: s_d.rdata = 16'(s_q.elapsed_s);
                default: begin
                    if (addr_in >= OFS_ID1_BASE && int'(addr_in) < int'(OFS_ID1_BASE) + ID1_DEPTH) begin
                        s_d.rdata = 16'(s_q.id1[I1W'(addr_in - OFS_ID1_BASE)]);
                    end
                    if (addr_in >= OFS_ID2_BASE && int'(addr_in) < int'(OFS_ID2_BASE) + ID2_DEPTH) begin
                        s_d.rdata = 16'(s_q.id2[8'(addr_in - OFS_ID2_BASE)]);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            s_q            <= '0;
            s_q.ctrl       <= RST_CTRL;
            s_q.tone_hz    <= RST_TONE;
            s_q.repeat_min <= RST_REPEAT;
            s_q.words_per_minute        <= RST_WPM;
            s_q.wait_s     <= RST_WAIT;
            s_q.porch_ds   <= RST_PORCH;
            s_q.timeout_s  <= RST_TIMEOUT;
            s_q.dropout_s  <= RST_DROPOUT;
            s_q.seq        <= MSI_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out           = s_q.rdata;
    assign transmitter_key_out = s_q.key_q;
    assign tone_out            = s_q.tone_q;
    assign id_active_out       = (s_q.seq != MSI_IDLE);

endmodule

/* File: sim/msi_checker.sv */
// msi_checker: port assertions for the station id controller.
// assumes it is bound onto the controller top.
`timescale 1ns/1ps
module msi_checker (
    input wire logic                       clock_in,
    input wire logic                       reset_in,
    input wire logic                       rd_in,
    input wire logic [msi_pkg::DATA_W-1:0] rdata_out,
    input wire logic                       carrier_squelch_detect_in,
    input wire logic                       keying_request_in,
    input wire logic                       transmitter_key_out,
    input wire logic                       tone_out,
    input wire logic                       id_active_out
);
    // recent keying causes, synchroniser latency
    logic [7:0] act_q;
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            act_q <= 8'h00;
        end else begin
            act_q <= {act_q[6:0], carrier_squelch_detect_in | keying_request_in};
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    property p_req_keys;
        keying_request_in [*8] |-> transmitter_key_out;
    endproperty
    a_req_keys: assert property (p_req_keys)
        else $error("key low while request held");
    property p_key_cause;
        $rose(transmitter_key_out) |-> id_active_out || (|act_q[7:2]);
    endproperty
    a_key_cause: assert property (p_key_cause)
        else $error("key rose without a cause");
    property p_req_hang;
        $fell(keying_request_in) && transmitter_key_out |=> transmitter_key_out [*3];
    endproperty
    a_req_hang: assert property (p_req_hang)
        else $error("key dropped with request");
    property p_carrier_hang;
        $fell(carrier_squelch_detect_in) && transmitter_key_out |=> transmitter_key_out [*3];
    endproperty
    a_carrier_hang: assert property (p_carrier_hang)
        else $error("key dropped with carrier");
    property p_tone_gate;
        tone_out |-> id_active_out;
    endproperty
    a_tone_gate: assert property (p_tone_gate)
        else $error("tone outside identifier");
    property p_key_in_id;
        id_active_out && $past(id_active_out) |-> transmitter_key_out;
    endproperty
    a_key_in_id: assert property (p_key_in_id)
        else $error("key low during identifier");
    property p_porch_quiet;
        $rose(id_active_out) |-> !tone_out [*8];
    endproperty
    a_porch_quiet: assert property (p_porch_quiet)
        else $error("tone at identifier start");
    property p_rdata_idle;
        !$past(rd_in) |-> rdata_out == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without read");
endmodule
bind msi_morse_station_id_controller msi_checker msi_checker_i (
    .clock_in(clock_in), .reset_in(reset_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .carrier_squelch_detect_in(carrier_squelch_detect_in),
    .keying_request_in(keying_request_in), .transmitter_key_out(transmitter_key_out),
    .tone_out(tone_out), .id_active_out(id_active_out));

/* File: sim/msi_partner.sv */
// msi_partner: receiver squelch pins and transmitter seen from the controller.
// assumes bench commands on clock_in.
`timescale 1ns/1ps
module msi_partner (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       reset_in,
    // bench commands
    input  wire logic       carrier_cmd_in,
    input  wire logic       inhibit_cmd_in,
    input  wire logic       req_cmd_in,
    // controller pins
    input  wire logic       key_in,
    input  wire logic       tone_in,
    output logic            carrier_out,
    output logic            inhibit_out,
    output logic            req_out,
    // tone rises radiated while keyed
    output logic [7:0]      tone_rises_out
);
    logic tone_q;
    always @(posedge clock_in) begin
        carrier_out <= carrier_cmd_in;
        inhibit_out <= inhibit_cmd_in;
        req_out <= req_cmd_in;
        tone_q <= tone_in;
        if (reset_in) begin
            tone_rises_out <= 8'h00;
        end else if (key_in && tone_in && !tone_q) begin
            tone_rises_out <= tone_rises_out + 8'h01;
        end
    end
endmodule

/* File: sim/tb_top.sv */
// tb_top: self-checking bench for the station id controller.
// assumes the package, partner and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    import msi_pkg::*;
    localparam logic [40:0] ROWS [18] = '{
        {9'h001, 16'h0000, 16'h0001}, {9'h001, 16'h1388, 16'h0BB8}, {9'h001, 16'h04D2, 16'h04D2},
        {9'h002, 16'h0000, 16'h0001}, {9'h002, 16'h00C8, 16'h0063}, {9'h003, 16'h0000, 16'h0001},
        {9'h003, 16'h0064, 16'h0063}, {9'h004, 16'h0000, 16'h0001}, {9'h005, 16'h0096, 16'h0063},
        {9'h006, 16'h05DC, 16'h03E7}, {9'h007, 16'h0078, 16'h0063}, {9'h008, 16'h0014, 16'h0010},
        {9'h009, 16'h00C8, 16'h0082}, {9'h04F, 16'h0003, 16'h0003}, {9'h181, 16'h0006, 16'h0006},
        {9'h182, 16'h0055, 16'h0000}, {9'h0FF, 16'h0005, 16'h0000}, {9'h000, 16'hF005, 16'h0005}};
    localparam logic [15:0] DFLT [8] = '{16'h0000, 16'h03E8, 16'h000A, 16'h0014,
                                         16'h0005, 16'h0005, 16'h0000, 16'h0003};
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [8:0]  addr_in = 9'h000;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [15:0] rdata_out;
    logic        car_cmd = 1'b0;
    logic        inh_cmd = 1'b0;
    logic        req_cmd = 1'b0;
    logic        carrier;
    logic        inhibit;
    logic        req;
    logic        key;
    logic        tone;
    logic        id_act;
    logic [7:0]  rises;
    logic [7:0]  r0;
    logic [15:0] v;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          rel = 0;
    int          t0;
    int          n;
    msi_morse_station_id_controller #(.MS_CYCLES(1)) msi_morse_station_id_controller_i (
        .clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .carrier_squelch_detect_in(carrier), .inhibit_in(inhibit), .keying_request_in(req),
        .transmitter_key_out(key), .tone_out(tone), .id_active_out(id_act));
    msi_partner msi_partner_i (
        .clock_in(clock_in), .reset_in(reset_in), .carrier_cmd_in(car_cmd),
        .inhibit_cmd_in(inh_cmd), .req_cmd_in(req_cmd), .key_in(key), .tone_in(tone),
        .carrier_out(carrier), .inhibit_out(inhibit), .req_out(req), .tone_rises_out(rises));
    initial begin
        forever #50 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        rel <= reset_in ? 0 : rel + 1;
        if (cyc == 80000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp, input string what);
        chk({15'h0000, seen}, {15'h0000, exp}, what);
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(posedge clock_in);
        d = rdata_out;
    endtask
    task automatic hang_test(input logic use_req);
        @(posedge clock_in);
        {req_cmd, car_cmd} <= {use_req, !use_req};
        repeat (10) @(posedge clock_in);
        chk1(key, 1'b1, "key rise");
        repeat (290) @(posedge clock_in);
        {req_cmd, car_cmd} <= 2'b00;
        repeat (1900) @(posedge clock_in);
        chk1(key, 1'b1, "key hang");
        repeat (200) @(posedge clock_in);
        chk1(key, 1'b0, "key drop");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 18; i++) begin
            wr(ROWS[i][40:32], ROWS[i][31:16]);
            rd(ROWS[i][40:32], v);
            chk(v, ROWS[i][15:0], "reg row");
        end
        reset_in <= 1'b1;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(i[8:0], v);
            chk(v, DFLT[i], "reset value");
        end
        wr(OFS_DROPOUT, 16'h0002);
        hang_test(1'b1);
        hang_test(1'b0);
        @(posedge clock_in);
        inh_cmd <= 1'b1;
        repeat (100) @(posedge clock_in);
        chk1(key, 1'b0, "inhibit keyed");
        inh_cmd <= 1'b0;
        wr(OFS_TIMEOUT, 16'h0001);
        car_cmd <= 1'b1;
        repeat (900) @(posedge clock_in);
        chk1(key, 1'b1, "before timeout");
        repeat (200) @(posedge clock_in);
        chk1(key, 1'b0, "timeout");
        rd(OFS_STATUS, v);
        chk1(v[7], 1'b1, "timed out flag");
        car_cmd <= 1'b0;
        repeat (50) @(posedge clock_in);
        chk1(key, 1'b0, "hang after timeout");
        wr(OFS_TIMEOUT, 16'h0000);
        wr(OFS_PORCH, 16'h0002);
        wr(OFS_WPM, 16'h0001);
        wr(OFS_TONE, 16'h0BB8);
        wr(OFS_WAIT, 16'h0003);
        wr(OFS_REPEAT, 16'h0001);
        wr(OFS_ID1_LEN, 16'h0001);
        wr(OFS_ID1_BASE, 16'h0003);
        wr(OFS_CTRL, 16'h0003);
        while (rel < 58500) @(posedge clock_in);
        car_cmd <= 1'b1;
        while (rel < 59000) @(posedge clock_in);
        car_cmd <= 1'b0;
        n = 0;
        while (id_act !== 1'b1 && n < 5000) begin
            @(posedge clock_in);
            n++;
        end
        t0 = rel;
        r0 = rises;
        chk1(t0 >= 62000 && t0 <= 62030, 1'b1, "id start time");
        n = 0;
        repeat (190) begin
            @(posedge clock_in);
            if (tone !== 1'b0) n++;
        end
        chk(n[15:0], 16'h0000, "tone in porch");
        while (id_act !== 1'b0 && n < 9000) begin
            @(posedge clock_in);
            n++;
        end
        t0 = rel - t0;
        chk1(t0 >= 3800 && t0 <= 7420, 1'b1, "id length");
        chk1(rises - r0 >= 8'h01 && rises - r0 <= 8'h02, 1'b1, "tone rate");
        rd(OFS_ELAPSED, v);
        chk1(v >= t0 / 1000 && v <= t0 / 1000 + 2, 1'b1, "elapsed restart");
        repeat (10) @(posedge clock_in);
        chk1(key, 1'b0, "key after id");
        finish_test();
    end
endmodule
